/* src/timer16_pkg.sv */
// Constants shared by the 16-bit timer/counter block
package timer16_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned COUNT_W = 16;

   localparam logic [2:0] ADDR_TIMER_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_COUNT_LOW     = 3'h1;
   localparam logic [2:0] ADDR_COUNT_HIGH    = 3'h2;
   localparam logic [2:0] ADDR_COMPARE_LOW   = 3'h3;
   localparam logic [2:0] ADDR_COMPARE_HIGH  = 3'h4;
   localparam logic [2:0] ADDR_COMPARE_MODE  = 3'h5;
   localparam logic [2:0] ADDR_IRQ_STATUS    = 3'h6;
   localparam logic [2:0] ADDR_IRQ_MASK      = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Timer control register fields
   localparam int unsigned CTRL_TIMER_ON   = 0;
   localparam int unsigned CTRL_AUX_OSC_EN = 1;
   localparam int unsigned CTRL_CLK_SRC    = 2;
   localparam int unsigned CTRL_PRESC_LO   = 4;
   localparam int unsigned CTRL_PRESC_HI   = 5;
   localparam int unsigned CTRL_WIDE       = 7;
   localparam logic [7:0]  CTRL_WMASK      = 8'hB7;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Compare unit and interrupt layout
   localparam logic [3:0]  MODE_SPECIAL_EVENT = 4'hB;
   localparam logic [3:0]  MODE_RESET         = 4'h0;
   localparam int unsigned IRQ_OVERFLOW       = 0;
   localparam int unsigned IRQ_SPECIAL        = 1;
   localparam logic [1:0]  IRQ_RESET          = 2'h0;
   localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO         = 16'h0000;
   localparam logic [2:0]  PRESC_ZERO         = 3'h0;

endpackage : timer16_pkg

/* src/aux_osc.sv */
// Low-power auxiliary oscillator amplifier and count edge detector
`timescale 1ns/1ps
`default_nettype none
module aux_osc (
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   input  wire logic i_enable,
   input  wire logic i_osc_in,
   output var  logic o_osc_out,
   output var  logic o_rise
);
   logic in_q;
   logic out_q;

   // Enable is not gated by sleep, so the crystal keeps swinging
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         in_q  <= 1'b0;
         out_q <= 1'b0;
      end else begin
         in_q  <= i_osc_in;
         out_q <= i_enable & ~i_osc_in;
      end
   end

   assign o_osc_out = out_q;
   assign o_rise    = i_enable & i_osc_in & ~in_q;

   property p_osc_quiet_off;
      @(posedge i_core_clk) disable iff (i_reset)
      !i_enable |=> !o_osc_out;
   endproperty
   a_osc_quiet_off: assert property (p_osc_quiet_off) else $error("drive while off");
endmodule : aux_osc
`default_nettype wire

/* src/count_prescaler.sv */
// Count prescaler: 1, 2, 4 or 8 input pulses per count tick
`timescale 1ns/1ps
`default_nettype none
module count_prescaler (
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   input  wire logic       i_clear,
   input  wire logic       i_pulse,
   input  wire logic [1:0] i_ratio,
   output var  logic       o_tick
);
   logic [2:0] cnt_q;
   logic [2:0] mask;

   always_comb begin
      unique case (i_ratio)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         2'h3: mask = 3'h7;
      endcase
   end

   assign o_tick = i_pulse & ~i_clear & ((cnt_q & mask) == mask);

   always_ff @(posedge i_core_clk) begin
      if (i_reset || i_clear) begin
         cnt_q <= timer16_pkg::PRESC_ZERO;
      end else if (i_pulse) begin
         cnt_q <= o_tick ? timer16_pkg::PRESC_ZERO : 3'(cnt_q + 3'h1);
      end
   end

   property p_clear_empties;
      @(posedge i_core_clk) disable iff (i_reset)
      i_clear |=> cnt_q == 3'h0;
   endproperty
   a_clear_empties: assert property (p_clear_empties) else $error("not cleared");

   property p_clear_no_tick;
      @(posedge i_core_clk) disable iff (i_reset)
      i_clear |-> !o_tick;
   endproperty
   a_clear_no_tick: assert property (p_clear_no_tick) else $error("tick in clear");
endmodule : count_prescaler
`default_nettype wire

/* src/timer16.sv */
// 16-bit timer/counter with compare trigger, wide access and overflow interrupt
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The auxiliary oscillator is enabled only while its enable bit in the control register is set.
// - The auxiliary oscillator keeps running in sleep so the counter can still advance from it.
// - The counter counts up from 0000h to FFFFh and wraps back to 0000h.
// - Each wrap from FFFFh to zero sets the overflow flag, which stays set until software clears it.
// - The overflow flag raises the interrupt only while its enable bit is set.
// - With compare mode 1011 each trigger resets the counter and starts a conversion if enabled.
// - A trigger reset never sets the overflow flag.
// - A counter write in the same cycle as a trigger wins over the trigger reset.
// - With trigger resets active the counter wraps to zero on a compare match, giving a period of compare plus one.
// - With wide access on, the high-byte address maps to a high-byte buffer.
// - With wide access on, a low-byte read copies the live high byte into the buffer.
// - With wide access on, a low-byte write loads the live high byte from the buffer at once.
// - With wide access on, the live high byte is neither read nor written directly.
// - A low-byte write clears the prescaler and a high-byte write leaves it alone.
module timer16 (
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_sleep,
   input  wire logic       i_adc_enable,
   input  wire logic       i_aux_osc_in_pin,
   output var  logic [7:0] o_rdata,
   output var  logic       o_aux_osc_out_pin,
   output var  logic       o_aux_osc_enable,
   output var  logic       o_adc_start,
   output var  logic       o_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]  ctrl_q;
   logic [15:0] count_q;
   logic [7:0]  high_buf_q;
   logic [15:0] compare_q;
   logic [3:0]  compare_mode_q;
   logic [1:0]  status_q;
   logic [1:0]  mask_q;
   logic [7:0]  rdata_q;

   logic wr_low;
   logic wr_high;
   logic rd_low;
   logic rd_high;
   logic wide;
   logic osc_rise;
   logic src_pulse;
   logic tick;
   logic count_write;
   logic special_sel;
   logic trig_event;
   logic overflow_event;

   function automatic logic hit(input logic [2:0] addr, input logic [2:0] target);
      hit = (addr == target);
   endfunction : hit

   assign wide    = ctrl_q[timer16_pkg::CTRL_WIDE];
   assign wr_low  = i_wr & hit(i_addr, timer16_pkg::ADDR_COUNT_LOW);
   assign wr_high = i_wr & hit(i_addr, timer16_pkg::ADDR_COUNT_HIGH);
   assign rd_low  = i_rd & hit(i_addr, timer16_pkg::ADDR_COUNT_LOW);
   assign rd_high = i_rd & hit(i_addr, timer16_pkg::ADDR_COUNT_HIGH);

   ////////////////////////////////////////////////////////////////////////////
   // Count source and prescaler
   aux_osc u_aux_osc (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_enable   (ctrl_q[timer16_pkg::CTRL_AUX_OSC_EN]),
      .i_osc_in   (i_aux_osc_in_pin),
      .o_osc_out  (o_aux_osc_out_pin),
      .o_rise     (osc_rise)
   );

   assign o_aux_osc_enable = ctrl_q[timer16_pkg::CTRL_AUX_OSC_EN];

   // System clock counting halts in sleep; oscillator counting does not
   assign src_pulse = ctrl_q[timer16_pkg::CTRL_TIMER_ON]
                    & (ctrl_q[timer16_pkg::CTRL_CLK_SRC] ? osc_rise : ~i_sleep);

   count_prescaler u_prescaler (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_clear    (wr_low),
      .i_pulse    (src_pulse),
      .i_ratio    (ctrl_q[timer16_pkg::CTRL_PRESC_HI:timer16_pkg::CTRL_PRESC_LO]),
      .o_tick     (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Events
   // Only synchronous counting is supported, so the trigger is always safe here
   assign count_write    = wr_low | (wr_high & ~wide);
   assign special_sel    = (compare_mode_q == timer16_pkg::MODE_SPECIAL_EVENT);
   assign trig_event     = tick & special_sel & (count_q == compare_q)
                         & ~count_write;
   assign overflow_event = tick & ~count_write & ~trig_event
                         & (count_q == timer16_pkg::COUNT_MAX);
   assign o_adc_start    = trig_event & i_adc_enable;

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         count_q <= timer16_pkg::COUNT_ZERO;
      end else if (wr_low) begin
         count_q[7:0] <= i_wdata;
         if (wide) begin
            count_q[15:8] <= high_buf_q;
         end
      end else if (wr_high && !wide) begin
         count_q[15:8] <= i_wdata;
      end else if (trig_event) begin
         count_q <= timer16_pkg::COUNT_ZERO;
      end else if (tick) begin
         count_q <= 16'(count_q + 16'h0001);
      end
   end

   // High-byte buffer
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         high_buf_q <= 8'h00;
      end else if (wide && rd_low) begin
         high_buf_q <= count_q[15:8];
      end else if (wide && wr_high) begin
         high_buf_q <= i_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ctrl_q <= timer16_pkg::CTRL_RESET;
      end else if (i_wr && hit(i_addr, timer16_pkg::ADDR_TIMER_CONTROL)) begin
         ctrl_q <= i_wdata & timer16_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         compare_q      <= timer16_pkg::COUNT_ZERO;
         compare_mode_q <= timer16_pkg::MODE_RESET;
      end else if (i_wr) begin
         if (hit(i_addr, timer16_pkg::ADDR_COMPARE_LOW)) begin
            compare_q[7:0] <= i_wdata;
         end
         if (hit(i_addr, timer16_pkg::ADDR_COMPARE_HIGH)) begin
            compare_q[15:8] <= i_wdata;
         end
         if (hit(i_addr, timer16_pkg::ADDR_COMPARE_MODE)) begin
            compare_mode_q <= i_wdata[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky status, cleared by reading it; a new event wins
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         status_q <= timer16_pkg::IRQ_RESET;
      end else begin
         status_q <= (i_rd && hit(i_addr, timer16_pkg::ADDR_IRQ_STATUS) ? 2'h0 : status_q)
                   | {trig_event, overflow_event};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         mask_q <= timer16_pkg::IRQ_RESET;
      end else if (i_wr && hit(i_addr, timer16_pkg::ADDR_IRQ_MASK)) begin
         mask_q <= i_wdata[1:0];
      end
   end

   assign o_irq = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_reset || !i_rd) begin
         rdata_q <= 8'h00;
      end else begin
         unique case (i_addr)
            timer16_pkg::ADDR_TIMER_CONTROL: rdata_q <= ctrl_q;
            timer16_pkg::ADDR_COUNT_LOW:     rdata_q <= count_q[7:0];
            timer16_pkg::ADDR_COUNT_HIGH:
               rdata_q <= wide ? high_buf_q : count_q[15:8];
            timer16_pkg::ADDR_COMPARE_LOW:   rdata_q <= compare_q[7:0];
            timer16_pkg::ADDR_COMPARE_HIGH:  rdata_q <= compare_q[15:8];
            timer16_pkg::ADDR_COMPARE_MODE:  rdata_q <= {4'h0, compare_mode_q};
            timer16_pkg::ADDR_IRQ_STATUS:    rdata_q <= {6'h00, status_q};
            timer16_pkg::ADDR_IRQ_MASK:      rdata_q <= {6'h00, mask_q};
         endcase
      end
   end

   assign o_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_osc_sleep;
      @(posedge i_core_clk) disable iff (i_reset)
      (o_aux_osc_enable && i_sleep) |=> o_aux_osc_out_pin == !$past(i_aux_osc_in_pin);
   endproperty
   a_osc_sleep: assert property (p_osc_sleep) else $error("oscillator off in sleep");

   property p_count_up;
      @(posedge i_core_clk) disable iff (i_reset)
      (tick && !count_write && !trig_event) |=> count_q == 16'($past(count_q) + 16'h0001);
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter did not advance");

   property p_overflow_flag;
      @(posedge i_core_clk) disable iff (i_reset)
      overflow_event |=> status_q[0] && count_q == 16'h0000;
   endproperty
   a_overflow_flag: assert property (p_overflow_flag) else $error("wrap lost flag");

   property p_irq_gate;
      @(posedge i_core_clk) disable iff (i_reset)
      (status_q[0] && !mask_q[0] && !(status_q[1] && mask_q[1])) |-> !o_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("masked overflow raised irq");

   property p_trig_reset;
      @(posedge i_core_clk) disable iff (i_reset)
      trig_event |-> (o_adc_start == i_adc_enable) ##1 count_q == 16'h0000;
   endproperty
   a_trig_reset: assert property (p_trig_reset) else $error("trigger reset failed");

   property p_trig_no_flag;
      @(posedge i_core_clk) disable iff (i_reset)
      (trig_event && !status_q[0]) |=> !status_q[0];
   endproperty
   a_trig_no_flag: assert property (p_trig_no_flag) else $error("trigger set overflow");

   // A low write never meets a tick: it empties the prescaler first
   property p_write_wins;
      @(posedge i_core_clk) disable iff (i_reset)
      (wr_high && !wide && tick && special_sel && count_q == compare_q)
         |=> count_q[15:8] == $past(i_wdata) && !$past(o_adc_start);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

   property p_latch_high;
      @(posedge i_core_clk) disable iff (i_reset)
      (wide && rd_low) |=> high_buf_q == $past(count_q[15:8]);
   endproperty
   a_latch_high: assert property (p_latch_high) else $error("buffer not latched");

   property p_load_high;
      @(posedge i_core_clk) disable iff (i_reset)
      (wide && wr_low) |=> count_q[15:8] == $past(high_buf_q);
   endproperty
   a_load_high: assert property (p_load_high) else $error("high byte not loaded");

   property p_buffer_read;
      @(posedge i_core_clk) disable iff (i_reset)
      (wide && rd_high) |=> o_rdata == $past(high_buf_q);
   endproperty
   a_buffer_read: assert property (p_buffer_read) else $error("live high byte read");

   property p_direct_high;
      @(posedge i_core_clk) disable iff (i_reset)
      (!wide && wr_high) |=> count_q[15:8] == $past(i_wdata);
   endproperty
   a_direct_high: assert property (p_direct_high) else $error("direct write lost");

   property p_irq_raise;
      @(posedge i_core_clk) disable iff (i_reset)
      (status_q[0] && mask_q[0]) |-> o_irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("irq missing");

   property p_flag_sticky;
      @(posedge i_core_clk) disable iff (i_reset)
      (status_q[0] && !(i_rd && i_addr == timer16_pkg::ADDR_IRQ_STATUS)) |=> status_q[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag not held");

   property p_flag_clear;
      @(posedge i_core_clk) disable iff (i_reset)
      (i_rd && i_addr == timer16_pkg::ADDR_IRQ_STATUS && !overflow_event && !trig_event)
         |=> status_q == 2'h0;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_buffer_write;
      @(posedge i_core_clk) disable iff (i_reset)
      (wide && wr_high) |=> high_buf_q == $past(i_wdata);
   endproperty
   a_buffer_write: assert property (p_buffer_write) else $error("no buffer write");

   // A tick may still carry into the live high byte, so only idle cycles are checked
   property p_live_high_kept;
      @(posedge i_core_clk) disable iff (i_reset)
      (wide && wr_high && !tick) |=> count_q[15:8] == $past(count_q[15:8]);
   endproperty
   a_live_high_kept: assert property (p_live_high_kept) else $error("high written");

endmodule : timer16
`default_nettype wire

/* verif/timer16_tb.sv */
// Self-checking register-level testbench for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer16_tb;

   ////////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic       core_clk   = 1'b0;
   logic       reset      = 1'b1;
   logic [2:0] addr       = 3'h0;
   logic [7:0] wdata      = 8'h00;
   logic       wr         = 1'b0;
   logic       rd         = 1'b0;
   logic       sleep      = 1'b1;
   logic       adc_enable = 1'b0;
   logic       osc_pin    = 1'b0;
   logic [7:0] rdata;
   logic       osc_out;
   logic       osc_enable;
   logic       adc_start;
   logic       irq;
   int         n_fail     = 0;
   int         compares   = 0;
   int         n_adc      = 0;

   always #2.5 core_clk = ~core_clk;

   timer16 i_dut (
      .i_core_clk        (core_clk),
      .i_reset           (reset),
      .i_addr            (addr),
      .i_wdata           (wdata),
      .i_wr              (wr),
      .i_rd              (rd),
      .i_sleep           (sleep),
      .i_adc_enable      (adc_enable),
      .i_aux_osc_in_pin  (osc_pin),
      .o_rdata           (rdata),
      .o_aux_osc_out_pin (osc_out),
      .o_aux_osc_enable  (osc_enable),
      .o_adc_start       (adc_start),
      .o_irq             (irq)
   );

   // Conversion start is a one-cycle pulse, so count it at every edge
   always @(posedge core_clk) begin
      if (adc_start === 1'b1) begin
         n_adc++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr    <= 1'b0;
      #1;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd   <= 1'b0;
      #1;
      check({8'h00, rdata}, {8'h00, exp});
   endtask : rd_chk

   // Slow crystal edges, well apart so the edge detector sees each one
   task automatic osc_rises(input int n);
      repeat (n) begin
         repeat (3) @(posedge core_clk);
         osc_pin <= 1'b1;
         repeat (3) @(posedge core_clk);
         osc_pin <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      #1;
   endtask : osc_rises

   task automatic final_report;
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      rd_chk(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(timer16_pkg::ADDR_IRQ_STATUS, 8'h00);
      check({15'h0000, irq}, 16'h0000);
      check({15'h0000, osc_enable}, 16'h0000);
      // Control write mask and oscillator enable
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'hFF);
      rd_chk(timer16_pkg::ADDR_TIMER_CONTROL, 8'hB7);
      check({15'h0000, osc_enable}, 16'h0001);
      check({15'h0000, osc_out}, 16'h0001);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      check({15'h0000, osc_enable}, 16'h0000);
      // Direct byte access with wide mode off
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h12);
      reg_wr(timer16_pkg::ADDR_COUNT_LOW, 8'h34);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h34);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h12);
      // System-clock counting halts in sleep
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h01);
      repeat (10) @(posedge core_clk);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h34);
      // Wide access through the high-byte buffer
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h80);
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h9A);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h9A);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h34);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h12);
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h9A);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h12);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h80);
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h9A);
      reg_wr(timer16_pkg::ADDR_COUNT_LOW, 8'hBC);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h9A);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'hBC);
      // Wrap from the top, counted from the crystal during sleep
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'hFF);
      reg_wr(timer16_pkg::ADDR_COUNT_LOW, 8'hFE);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h02);
      repeat (20) @(posedge core_clk);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h07);
      osc_rises(2);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h00);
      check({15'h0000, irq}, 16'h0000);
      reg_wr(timer16_pkg::ADDR_IRQ_MASK, 8'h01);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(timer16_pkg::ADDR_IRQ_STATUS, 8'h01);
      rd_chk(timer16_pkg::ADDR_IRQ_STATUS, 8'h00);
      check({15'h0000, irq}, 16'h0000);
      // Special event trigger with a period of compare plus one
      reg_wr(timer16_pkg::ADDR_COMPARE_LOW, 8'h03);
      reg_wr(timer16_pkg::ADDR_COMPARE_HIGH, 8'h00);
      reg_wr(timer16_pkg::ADDR_COMPARE_MODE, 8'h0B);
      reg_wr(timer16_pkg::ADDR_IRQ_MASK, 8'h02);
      adc_enable <= 1'b1;
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h07);
      osc_rises(3);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h03);
      check(n_adc[15:0], 16'h0000);
      osc_rises(1);
      check(n_adc[15:0], 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      adc_enable <= 1'b0;
      osc_rises(4);
      check(n_adc[15:0], 16'h0001);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h00);
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h00);
      rd_chk(timer16_pkg::ADDR_IRQ_STATUS, 8'h02);
      // High write against a trigger on every tick: compare zero, system clock, awake
      reg_wr(timer16_pkg::ADDR_COMPARE_LOW, 8'h00);
      sleep <= 1'b0;
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h01);
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h55);
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
      sleep <= 1'b1;
      rd_chk(timer16_pkg::ADDR_COUNT_HIGH, 8'h55);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h02);
      reg_wr(timer16_pkg::ADDR_COMPARE_MODE, 8'h00);
      // Prescaler of eight: low write clears it, high write does not
      reg_wr(timer16_pkg::ADDR_TIMER_CONTROL, 8'h37);
      osc_rises(7);
      reg_wr(timer16_pkg::ADDR_COUNT_LOW, 8'h00);
      osc_rises(7);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h00);
      reg_wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h00);
      osc_rises(1);
      rd_chk(timer16_pkg::ADDR_COUNT_LOW, 8'h01);
      final_report();
   end

endmodule : timer16_tb
`default_nettype wire
